// ===== rtl/pulse_freq_map.vh
// Constants for the pulse frequency output block.
// Assumes inclusion by bare name from rtl design files.
`ifndef PULSE_FREQ_MAP_VH
`define PULSE_FREQ_MAP_VH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PF_CLK_HZ 25000000
`define PF_TICK_US 100
`define PF_FREQ_MIN_HZ 12'h0c8
`define PF_FREQ_MAX_HZ 12'h9c4

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define PF_FREQ_W 12
`define PF_CNT_W 16
`define PF_CH_W 3
`define PF_CH_NUM 8
`define PF_PER_W 16
`define PF_ZERO_CNT 16'h0000
`define PF_ZERO_PER 16'h0000
`define PF_ONE_PER 16'h0001

// ----------------------------------------------------------------------
// Generator states
// ----------------------------------------------------------------------
`define PF_ST_IDLE 2'h0
`define PF_ST_RUN 2'h1
`define PF_ST_HOLD 2'h2
`define PF_ST_DONE 2'h3

`endif

// ===== rtl/pulse_cycle_tick.v
// Module cycle tick source: one pulse per internal processing cycle.
// Assumes a free running core clock and an asynchronous low reset.
`timescale 1ns/100ps
`default_nettype none
`include "pulse_freq_map.vh"

module pulse_cycle_tick #(
    parameter integer DIV = 2500
) (
    input wire clk_i,
    input wire reset_n_i,
    input wire run_i,
    output reg tick_o
);

    reg [15:0] cnt_r;

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------
    // Restart with each run so the first cycle is a full one
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r <= `PF_ZERO_PER;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            cnt_r <= `PF_ZERO_PER;
            tick_o <= 1'b0;
        end else if (cnt_r == DIV[15:0] - `PF_ONE_PER) begin
            cnt_r <= `PF_ZERO_PER;
            tick_o <= 1'b1;
        end else begin
            cnt_r <= cnt_r + `PF_ONE_PER;
            tick_o <= 1'b0;
        end
    end

endmodule // pulse_cycle_tick
`default_nettype wire

// ===== rtl/pulse_frequency_output.v
// Pulse frequency output for one channel of a counter module.
// Assumes controller inputs come from another domain; start and
// stop are synchronised here. One core clock of 25 MHz.
`timescale 1ns/100ps
`default_nettype none
`include "pulse_freq_map.vh"

// Function
// - Frequency range 0.2 to 2.5 kHz
// - Pulse lengths are whole module cycles
// - Edge jitter set by module cycle
// - Output on one selected channel only
// - Zero count means endless pulses
// - Start on rising edge of start
// - Start low aborts output
// - Stop rising edge suspends, keeps sequence
// - Stop low resumes output
// - Nonzero count emits exactly that many, one fewer if stop is high at start
// - Done flag after last pulse
module pulse_frequency_output #(
    parameter integer CYCLE_US = `PF_TICK_US,
    parameter integer NCH = `PF_CH_NUM
) (
    input wire CORE_CLK_I,
    input wire RESET_N_I,
    input wire START_I,
    input wire STOP_I,
    input wire [`PF_FREQ_W-1:0] TARGET_FREQUENCY_I,
    input wire [`PF_CNT_W-1:0] PULSE_COUNT_I,
    input wire [`PF_CH_W-1:0] CHANNEL_SELECT_I,
    output reg [NCH-1:0] CHANNEL_OUT_O,
    output reg DONE_FLAG_O,
    output reg BUSY_O,
    output reg PULSES_SENT_O_UNUSED_O
);

    // ------------------------------------------------------------------
    // Derived timing
    // ------------------------------------------------------------------
    // Core clocks per module cycle
    localparam integer TICK_DIV = (`PF_CLK_HZ / 1000000) * CYCLE_US;
    // Module cycles per second
    localparam integer TICKS_PER_S = 1000000 / CYCLE_US;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    reg start_s1_r, start_s2_r, start_d_r;
    reg stop_s1_r, stop_s2_r, stop_d_r;

    // Two synchroniser flops and one edge delay flop per asynchronous control level
    always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            start_s1_r <= 1'b0;
            start_s2_r <= 1'b0;
            start_d_r <= 1'b0;
            stop_s1_r <= 1'b0;
            stop_s2_r <= 1'b0;
            stop_d_r <= 1'b0;
        end else begin
            start_s1_r <= START_I;
            start_s2_r <= start_s1_r;
            start_d_r <= start_s2_r;
            stop_s1_r <= STOP_I;
            stop_s2_r <= stop_s1_r;
            stop_d_r <= stop_s2_r;
        end
    end

    wire start_rise = start_s2_r & ~start_d_r;
    wire stop_rise = stop_s2_r & ~stop_d_r;

    // ------------------------------------------------------------------
    // Period computation
    // ------------------------------------------------------------------
    // Clamp the requested frequency to the legal range
    reg [`PF_FREQ_W-1:0] freq_clamp;
    reg [`PF_PER_W-1:0] half_calc;
    reg [31:0] half_wide;

    // Half period in module cycles, at least one
    always @* begin
        freq_clamp = TARGET_FREQUENCY_I;
        if (TARGET_FREQUENCY_I < `PF_FREQ_MIN_HZ)
            freq_clamp = `PF_FREQ_MIN_HZ;
        else if (TARGET_FREQUENCY_I > `PF_FREQ_MAX_HZ)
            freq_clamp = `PF_FREQ_MAX_HZ;
        half_wide = TICKS_PER_S / (2 * freq_clamp);
        // Range clamp keeps the quotient inside the period width
        half_calc = half_wide[`PF_PER_W-1:0];
        if (half_calc == `PF_ZERO_PER)
            half_calc = `PF_ONE_PER;
    end

    // ------------------------------------------------------------------
    // Generator state
    // ------------------------------------------------------------------
    reg [1:0] state_r, state_nxt;
    reg [`PF_PER_W-1:0] half_r, phase_cnt_r;
    reg [`PF_CNT_W-1:0] target_r, sent_r;
    reg [`PF_CH_W-1:0] chan_r;
    reg level_r;
    reg done_nxt;
    wire tick;
    wire endless = (target_r == `PF_ZERO_CNT);

    // Module cycle divider
    pulse_cycle_tick #(
        .DIV(TICK_DIV)
    ) u_tick (
        .clk_i(CORE_CLK_I),
        .reset_n_i(RESET_N_I),
        .run_i(state_r == `PF_ST_RUN),
        .tick_o(tick)
    );

    // Next state
    always @* begin
        state_nxt = state_r;
        case (state_r)
            `PF_ST_IDLE, `PF_ST_DONE: begin
                if (start_rise)
                    state_nxt = stop_s2_r ? `PF_ST_HOLD : `PF_ST_RUN;
            end
            `PF_ST_RUN: begin
                if (stop_rise)
                    state_nxt = `PF_ST_HOLD;
                else if (tick && level_r == 1'b0 && !endless &&
                         phase_cnt_r == `PF_ONE_PER &&
                         sent_r == target_r)
                    state_nxt = `PF_ST_DONE;
            end
            `PF_ST_HOLD: begin
                if (!stop_s2_r)
                    state_nxt = `PF_ST_RUN;
            end
            default: state_nxt = `PF_ST_IDLE;
        endcase
        if (!start_s2_r && state_r != `PF_ST_DONE)
            state_nxt = `PF_ST_IDLE;
    end

    // Done flag next value
    always @* begin
        done_nxt = DONE_FLAG_O;
        if (state_nxt == `PF_ST_DONE && state_r == `PF_ST_RUN)
            done_nxt = 1'b1;
        if (start_rise)
            done_nxt = 1'b0;
    end

    // Sequencer registers
    always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_r <= `PF_ST_IDLE;
            half_r <= `PF_ONE_PER;
            phase_cnt_r <= `PF_ONE_PER;
            target_r <= `PF_ZERO_CNT;
            sent_r <= `PF_ZERO_CNT;
            chan_r <= {`PF_CH_W{1'b0}};
            level_r <= 1'b0;
            DONE_FLAG_O <= 1'b0;
        end else begin
            state_r <= state_nxt;
            DONE_FLAG_O <= done_nxt;
            if (start_rise && state_nxt != `PF_ST_IDLE) begin
                // Latch settings for the new sequence
                half_r <= half_calc;
                phase_cnt_r <= half_calc;
                target_r <= PULSE_COUNT_I;
                chan_r <= CHANNEL_SELECT_I;
                sent_r <= PULSE_COUNT_I == `PF_ZERO_CNT ?
                          `PF_ZERO_CNT : `PF_CNT_W'h0001;
                // Stop already high at start: wait low in suspend
                level_r <= (state_nxt == `PF_ST_RUN);
            end else if (state_nxt == `PF_ST_IDLE ||
                         state_nxt == `PF_ST_DONE ||
                         state_nxt == `PF_ST_HOLD) begin
                level_r <= 1'b0;
                // Resume starts with a full low phase
                phase_cnt_r <= half_r;
            end else if (state_r == `PF_ST_RUN && tick) begin
                if (phase_cnt_r == `PF_ONE_PER) begin
                    phase_cnt_r <= half_r;
                    level_r <= ~level_r;
                    if (!level_r && !endless)
                        sent_r <= sent_r + `PF_CNT_W'h0001;
                end else begin
                    phase_cnt_r <= phase_cnt_r - `PF_ONE_PER;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi = gi + 1) begin : g_chan
            always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
                if (!RESET_N_I)
                    CHANNEL_OUT_O[gi] <= 1'b0;
                else
                    CHANNEL_OUT_O[gi] <= level_r &&
                                         (chan_r == gi);
            end
        end
    endgenerate

    // Status flags
    always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            BUSY_O <= 1'b0;
            PULSES_SENT_O_UNUSED_O <= 1'b0;
        end else begin
            // Busy drops together with the done flag rising
            BUSY_O <= (state_nxt == `PF_ST_RUN) ||
                      (state_nxt == `PF_ST_HOLD);
            PULSES_SENT_O_UNUSED_O <= (state_r == `PF_ST_HOLD);
        end
    end

endmodule // pulse_frequency_output
`default_nettype wire

// ===== verification/pulse_ctrl_model.sv
// Controller model: drives start, stop and the pulse settings.
// Assumes the bench clock; every change after time zero lands 1 ns after an edge.
`timescale 1ns/100ps
`default_nettype none
`include "pulse_freq_map.vh"
module pulse_ctrl_model (
    input wire logic clk_i,
    output logic start_o,
    output logic stop_o,
    output logic [`PF_FREQ_W-1:0] freq_o,
    output logic [`PF_CNT_W-1:0] count_o,
    output logic [`PF_CH_W-1:0] chan_o
);
    // Quiet controller at time zero
    initial begin
        {start_o, stop_o, freq_o, count_o, chan_o} = '0;
    end
    // Start and stop levels, changed just after an edge
    task automatic drive(input logic go, input logic hold);
        @(posedge clk_i);
        #1;
        start_o = go;
        stop_o = hold;
    endtask
    // settings fixed before the start edge
    task automatic setup(input logic [`PF_FREQ_W-1:0] f,
        input logic [`PF_CNT_W-1:0] n, input logic [`PF_CH_W-1:0] c);
        @(posedge clk_i);
        #1;
        {freq_o, count_o, chan_o} = {f, n, c};
    endtask
endmodule // pulse_ctrl_model
`default_nettype wire

// ===== verification/pulse_frequency_output_props.sv
// Checker for the pulse frequency output block, bound to its ports.
// Assumes one core clock and an active low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module pulse_frequency_output_props #(
    parameter integer NCH = 8
) (
    input wire logic CORE_CLK_I,
    input wire logic RESET_N_I,
    input wire logic START_I,
    input wire logic STOP_I,
    input wire logic [NCH-1:0] CHANNEL_OUT_O,
    input wire logic DONE_FLAG_O,
    input wire logic BUSY_O,
    input wire logic PULSES_SENT_O_UNUSED_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    // Start rise held long enough to pass the synchroniser
    sequence s_go;
        !START_I ##1 (START_I && !STOP_I) [*6];
    endsequence
    // Controller quiet, no abort and no stop
    sequence s_calm;
        (START_I && !STOP_I) [*8];
    endsequence
    a_start_go_busy: assert property (s_go |-> BUSY_O)
        else $error("start rise did not start");
    a_start_done_clr: assert property (s_go |-> !DONE_FLAG_O)
        else $error("done not cleared on start");
    a_abort_out_low: assert property (!START_I [*6] |->
        CHANNEL_OUT_O == 0 && !BUSY_O)
        else $error("start low did not abort");
    a_one_channel: assert property ($onehot0(CHANNEL_OUT_O))
        else $error("more than one channel active");
    a_hold_out_low: assert property (PULSES_SENT_O_UNUSED_O |->
        CHANNEL_OUT_O == 0 && BUSY_O)
        else $error("suspend not holding");
    a_done_after_run: assert property ($rose(DONE_FLAG_O) |->
        $past(BUSY_O))
        else $error("done without a run");
    a_done_is_idle: assert property (DONE_FLAG_O |->
        !BUSY_O && CHANNEL_OUT_O == 0)
        else $error("output after done");
    a_min_high_phase: assert property (s_calm ##0
        $rose(|CHANNEL_OUT_O) ##1 s_calm |-> |CHANNEL_OUT_O)
        else $error("high phase shorter than a cycle");
endmodule // pulse_frequency_output_props
bind pulse_frequency_output pulse_frequency_output_props #(.NCH(NCH))
    i_pulse_frequency_output_props (.CORE_CLK_I(CORE_CLK_I),
    .RESET_N_I(RESET_N_I), .START_I(START_I), .STOP_I(STOP_I),
    .CHANNEL_OUT_O(CHANNEL_OUT_O), .DONE_FLAG_O(DONE_FLAG_O),
    .BUSY_O(BUSY_O), .PULSES_SENT_O_UNUSED_O(PULSES_SENT_O_UNUSED_O));
`default_nettype wire

// ===== verification/pulse_frequency_output_tb_top.sv
// Bench for the pulse frequency output block with a controller model.
// Assumes the design, model and checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "pulse_freq_map.vh"
module pulse_frequency_output_tb_top;
    localparam int CYC = 4;
    localparam int MC = 25 * CYC;
    logic clk = 0;
    logic rst_n = 0;
    wire start, stop, done, busy, hold;
    wire [`PF_FREQ_W-1:0] freq;
    wire [`PF_CNT_W-1:0] cnt;
    wire [`PF_CH_W-1:0] chan;
    wire [7:0] ch_out;
    int fail_count = 0;
    int samples_checked = 0;
    int rises, hi_len, lo_len, run;
    logic [7:0] last = 0;
    logic [7:0] seen = 0;
    always #20 clk = ~clk;
    pulse_ctrl_model i_pulse_ctrl_model (.clk_i(clk), .start_o(start),
        .stop_o(stop), .freq_o(freq), .count_o(cnt), .chan_o(chan));
    pulse_frequency_output #(.CYCLE_US(CYC), .NCH(8))
        i_pulse_frequency_output (.CORE_CLK_I(clk), .RESET_N_I(rst_n),
        .START_I(start), .STOP_I(stop), .TARGET_FREQUENCY_I(freq),
        .PULSE_COUNT_I(cnt), .CHANNEL_SELECT_I(chan),
        .CHANNEL_OUT_O(ch_out), .DONE_FLAG_O(done), .BUSY_O(busy),
        .PULSES_SENT_O_UNUSED_O(hold));
    // Phase lengths and rising edges on the outputs
    always @(posedge clk) begin
        run <= run + 1;
        seen <= seen | ch_out;
        if (ch_out !== last) begin
            if (|last) hi_len <= run;
            else lo_len <= run;
            if (|ch_out) rises <= rises + 1;
            run <= 1;
            last <= ch_out;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %0d want %0d", $time, got, exp);
        end
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Two pulses on channel 5, then done
    task automatic t_count;
        int i;
        rises = 0;
        seen = 0;
        i_pulse_ctrl_model.setup(12'h09c4, 16'h0002, 3'h5);
        i_pulse_ctrl_model.drive(1, 0);
        for (i = 0; i < 30000 && done !== 1'b1; i++) wait_clk(1);
        chk(done, 1);
        chk(rises, 2);
        chk(seen, 8'h20);
        chk(hi_len % MC, 0);
        chk(hi_len, lo_len);
        chk(hi_len + lo_len, 25000000 / 2500);
    endtask
    // Held start neither restarts nor drops done
    task automatic t_level;
        rises = 0;
        wait_clk(2000);
        chk(rises, 0);
        i_pulse_ctrl_model.drive(0, 0);
        wait_clk(8);
        chk(done, 1);
        i_pulse_ctrl_model.setup(12'h09c4, 16'h0000, 3'h2);
        i_pulse_ctrl_model.drive(1, 0);
        wait_clk(8);
        chk(done, 0);
    endtask
    // Endless run, suspend, resume and abort
    task automatic t_endless;
        int r;
        wait_clk(25000);
        chk(rises >= 2, 1);
        chk(done, 0);
        i_pulse_ctrl_model.drive(1, 1);
        wait_clk(8);
        chk({ch_out, busy}, 9'h001);
        r = rises;
        wait_clk(12000);
        chk(rises, r);
        i_pulse_ctrl_model.drive(1, 0);
        wait_clk(12000);
        chk(rises > r, 1);
        i_pulse_ctrl_model.drive(0, 0);
        wait_clk(8);
        chk({ch_out, busy}, 9'h000);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Reset, then the scenarios in order
    initial begin
        wait_clk(12);
        rst_n = 1;
        t_count;
        t_level;
        t_endless;
        report_and_stop;
    end
    // Watchdog cuts a hang short
    initial begin
        repeat (90000) @(posedge clk);
        fail_count++;
        report_and_stop;
    end
endmodule // pulse_frequency_output_tb_top
`default_nettype wire
